// [design/e1cc_pkg.sv]
package e1cc_pkg;
    // Port count and widths.
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 2;
    localparam int REG_W = 8;
    localparam int IDX_W = 8;
    localparam int BUILD_OUT_W = 3;
    localparam int SIG_W = 8;
    localparam int ADDR_W = 12;

    // Address layout: byte address = port * 2**PORT_LSB + index * 4.
    localparam int PORT_LSB = 10;
    localparam int IDX_LSB = 2;

    // Register indices.
    localparam logic [7:0] IDX_LINE_OPTION = 8'h16;
    localparam logic [7:0] IDX_LINE_INTF = 8'h1F;
    localparam logic [7:0] IDX_OUTPUT_SIG = 8'h2F;
    localparam logic [7:0] IDX_BUILD_OUT = 8'h30;
    localparam logic [7:0] IDX_STATUS_TWO = 8'h31;

    // Field positions.
    localparam int LOC_SYNC_IF_EN = 5;
    localparam int OSC_OTM_HI = 7;
    localparam int OSC_OTM_LO = 6;
    localparam int OSC_SIG_READ_SEL = 5;
    localparam int OSC_STATUS_SEL = 4;
    localparam int OSC_TS16_INSERT = 3;
    localparam int OSC_RESET = 0;
    localparam int LIC_RATIO_SEL = 3;
    localparam int LIC_LOOPBACK = 2;
    localparam int LIC_TX_SYNC_SEL = 0;
    localparam int ST2_BIT2 = 2;

    // Storable bits and reset value.
    localparam logic [7:0] LINE_OPTION_MASK = 8'hFF;
    localparam logic [7:0] OUTPUT_SIG_MASK = 8'hF8;
    localparam logic [7:0] LINE_INTF_MASK = 8'h0D;
    localparam logic [7:0] BUILD_OUT_MASK = 8'h07;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        OTM_NORMAL = 2'b00,
        OTM_HIZ = 2'b01,
        OTM_LOW = 2'b10,
        OTM_HIGH = 2'b11
    } e1cc_otm_e;
endpackage : e1cc_pkg

// [design/e1cc_port_if.sv]
`timescale 1ns/1ps
interface e1cc_port_if;
    logic wr_en;
    logic [7:0] wr_index;
    logic [7:0] wr_data;
    logic [7:0] line_option;
    logic [7:0] output_sig;
    logic [7:0] line_intf;
    logic [7:0] build_out;

    modport bus (
        output wr_en, wr_index, wr_data,
        input line_option, output_sig, line_intf, build_out
    );
    modport regs (
        input wr_en, wr_index, wr_data,
        output line_option, output_sig, line_intf, build_out
    );
endinterface : e1cc_port_if

// [design/e1cc_port_regs.sv]
`timescale 1ns/1ps
module e1cc_port_regs (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register access.
    e1cc_port_if.regs bus
);
    logic [7:0] line_option_ff;
    logic [7:0] output_sig_ff;
    logic [7:0] line_intf_ff;
    logic [7:0] build_out_ff;
    logic reset_last_ff;
    logic sw_reset;

    // Only a fresh low-to-high write of the reset bit clears the port.
    assign sw_reset = bus.wr_en && (bus.wr_index == e1cc_pkg::IDX_OUTPUT_SIG)
        && bus.wr_data[e1cc_pkg::OSC_RESET] && !reset_last_ff;

    // The written level is kept apart so a repeated 1 is not taken as an edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_last_ff <= 1'b0;
        end else if (bus.wr_en && (bus.wr_index == e1cc_pkg::IDX_OUTPUT_SIG)) begin
            reset_last_ff <= bus.wr_data[e1cc_pkg::OSC_RESET];
        end
    end

    // Unused bits are not stored and read back as zero, except in register 16h, which keeps all eight.
    always_ff @(posedge aclk) begin
        if (!aresetn || sw_reset) begin
            line_option_ff <= e1cc_pkg::REG_RESET_VAL;
            output_sig_ff <= e1cc_pkg::REG_RESET_VAL;
            line_intf_ff <= e1cc_pkg::REG_RESET_VAL;
            build_out_ff <= e1cc_pkg::REG_RESET_VAL;
        end else if (bus.wr_en) begin
            if (bus.wr_index == e1cc_pkg::IDX_LINE_OPTION) begin
                line_option_ff <= bus.wr_data & e1cc_pkg::LINE_OPTION_MASK;
            end else if (bus.wr_index == e1cc_pkg::IDX_OUTPUT_SIG) begin
                output_sig_ff <= bus.wr_data & e1cc_pkg::OUTPUT_SIG_MASK;
            end else if (bus.wr_index == e1cc_pkg::IDX_LINE_INTF) begin
                line_intf_ff <= bus.wr_data & e1cc_pkg::LINE_INTF_MASK;
            end else if (bus.wr_index == e1cc_pkg::IDX_BUILD_OUT) begin
                build_out_ff <= bus.wr_data & e1cc_pkg::BUILD_OUT_MASK;
            end
        end
    end

    assign bus.line_option = line_option_ff;
    assign bus.output_sig = output_sig_ff;
    assign bus.line_intf = line_intf_ff;
    assign bus.build_out = build_out_ff;
endmodule : e1cc_port_regs

// [design/e1cc_sync2.sv]
`timescale 1ns/1ps
module e1cc_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Data.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : e1cc_sync2

// [design/e1cc_top.sv]
// Operation
// - Both select bits low: normal transmit and receive.
// - Transmit-only select: send sync, receive normal E1.
// - Interface enable only: send and receive sync.
// - Both high: receive sync, transmit normal E1.
// - Sync mode passes 2.048MHz signal, transmit select bit0.
// - Output test mode: normal, high-Z, low, high.
// - Signaling read select picks receive or transmit data.
// - Status bit two: lost clock or signaling change.
// - Time slot 16 bit enables signaling insertion.
// - Reset bit rising edge clears port registers.
// - Analog loopback feeds transmit outputs to receiver.
// - Transformer select chooses 1:2 or 1:1.36/1:1.6.
// - Interface enable is bit 5 of register 16h.
`timescale 1ns/1ps
module e1cc_top #(
    parameter int NUM_PORTS = e1cc_pkg::NUM_PORTS
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [e1cc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [e1cc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit data from the framer and the sync generator.
    input wire logic [NUM_PORTS-1:0] tx_frame_tip,
    input wire logic [NUM_PORTS-1:0] tx_frame_ring,
    input wire logic [NUM_PORTS-1:0] tx_sync_tip,
    input wire logic [NUM_PORTS-1:0] tx_sync_ring,
    // Transmit line pins.
    output logic [NUM_PORTS-1:0] tx_line_tip_o,
    output logic [NUM_PORTS-1:0] tx_line_tip_oe,
    output logic [NUM_PORTS-1:0] tx_line_ring_o,
    output logic [NUM_PORTS-1:0] tx_line_ring_oe,
    // Receive line pins.
    input wire logic [NUM_PORTS-1:0] rx_line_tip,
    input wire logic [NUM_PORTS-1:0] rx_line_ring,
    // Receive data towards the framer and the sync recovery.
    output logic [NUM_PORTS-1:0] rx_frame_tip,
    output logic [NUM_PORTS-1:0] rx_frame_ring,
    output logic [NUM_PORTS-1:0] rx_sync_tip,
    output logic [NUM_PORTS-1:0] rx_sync_ring,
    // Mode indications.
    output logic [NUM_PORTS-1:0] tx_sync_mode,
    output logic [NUM_PORTS-1:0] rx_sync_mode,
    output logic [NUM_PORTS-1:0] transformer_ratio_select,
    output logic [NUM_PORTS*e1cc_pkg::BUILD_OUT_W-1:0] build_out_code,
    // Signaling.
    input wire logic [NUM_PORTS*e1cc_pkg::SIG_W-1:0] rx_sig_word,
    input wire logic [NUM_PORTS*e1cc_pkg::SIG_W-1:0] tx_sig_word,
    output logic [NUM_PORTS*e1cc_pkg::SIG_W-1:0] sig_read_word,
    output logic [NUM_PORTS-1:0] timeslot16_signaling_insert,
    // Status sources and the selected status bit.
    input wire logic [NUM_PORTS-1:0] loss_tx_clock,
    input wire logic [NUM_PORTS-1:0] sig_changed,
    output logic [NUM_PORTS-1:0] status_two_bit2
);
    // Write channel state.
    logic aw_got_ff;
    logic w_got_ff;
    logic [e1cc_pkg::ADDR_W-1:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wstrb_lo_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    // Read channel state.
    logic rvalid_ff;
    logic [7:0] rdata_ff;
    logic [1:0] rresp_ff;
    // Decode.
    logic wr_fire;
    logic [e1cc_pkg::PORT_W-1:0] wr_port;
    logic [e1cc_pkg::IDX_W-1:0] wr_index;
    logic wr_ok;
    logic [e1cc_pkg::PORT_W-1:0] rd_port;
    logic [e1cc_pkg::IDX_W-1:0] rd_index;
    // Per-port register copies.
    logic [7:0] line_option_q [NUM_PORTS];
    logic [7:0] output_sig_q [NUM_PORTS];
    logic [7:0] line_intf_q [NUM_PORTS];
    logic [7:0] build_out_q [NUM_PORTS];
    logic [NUM_PORTS-1:0] status_bit_ff;

    function automatic logic idx_writable(input logic [7:0] idx);
        logic ok;
        ok = 1'b0;
        if (idx == e1cc_pkg::IDX_LINE_OPTION) begin
            ok = 1'b1;
        end else if (idx == e1cc_pkg::IDX_LINE_INTF) begin
            ok = 1'b1;
        end else if (idx == e1cc_pkg::IDX_OUTPUT_SIG) begin
            ok = 1'b1;
        end else if (idx == e1cc_pkg::IDX_BUILD_OUT) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : idx_writable

    // Address and data are held until both have arrived, in either order.
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign wr_port = awaddr_ff[e1cc_pkg::PORT_LSB +: e1cc_pkg::PORT_W];
    assign wr_index = awaddr_ff[e1cc_pkg::IDX_LSB +: e1cc_pkg::IDX_W];
    assign wr_ok = idx_writable(wr_index) && (int'(wr_port) < NUM_PORTS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got_ff <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits; other lanes are dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_lo_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata[7:0];
            wstrb_lo_ff <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_got_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= e1cc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? e1cc_pkg::RESP_OKAY : e1cc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Read side: one outstanding read, data sampled at address acceptance.
    assign s_axi_arready = !rvalid_ff;
    assign rd_port = s_axi_araddr[e1cc_pkg::PORT_LSB +: e1cc_pkg::PORT_W];
    assign rd_index = s_axi_araddr[e1cc_pkg::IDX_LSB +: e1cc_pkg::IDX_W];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= e1cc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= e1cc_pkg::RESP_OKAY;
            rdata_ff <= '0;
            if (int'(rd_port) >= NUM_PORTS) begin
                rresp_ff <= e1cc_pkg::RESP_SLVERR;
            end else if (rd_index == e1cc_pkg::IDX_LINE_OPTION) begin
                rdata_ff <= line_option_q[rd_port];
            end else if (rd_index == e1cc_pkg::IDX_LINE_INTF) begin
                rdata_ff <= line_intf_q[rd_port];
            end else if (rd_index == e1cc_pkg::IDX_OUTPUT_SIG) begin
                rdata_ff <= output_sig_q[rd_port];
            end else if (rd_index == e1cc_pkg::IDX_BUILD_OUT) begin
                rdata_ff <= build_out_q[rd_port];
            end else if (rd_index == e1cc_pkg::IDX_STATUS_TWO) begin
                rdata_ff[e1cc_pkg::ST2_BIT2] <= status_bit_ff[rd_port];
            end else begin
                rresp_ff <= e1cc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = {24'h000000, rdata_ff};

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        e1cc_port_if port_bus ();
        logic [1:0] rx_pin_q;
        logic tx_src_tip;
        logic tx_src_ring;
        logic rx_src_tip;
        logic rx_src_ring;
        logic sync_if_en;
        logic tx_sync_sel;
        logic tx_sync_now;
        logic rx_sync_now;
        e1cc_pkg::e1cc_otm_e otm;

        // Write strobe reaches only the addressed port.
        assign port_bus.wr_en = wr_fire && wr_ok && wstrb_lo_ff
            && (wr_port == e1cc_pkg::PORT_W'(p));
        assign port_bus.wr_index = wr_index;
        assign port_bus.wr_data = wdata_ff;

        e1cc_port_regs u_regs (
            .aclk(aclk),
            .aresetn(aresetn),
            .bus(port_bus.regs)
        );

        assign line_option_q[p] = port_bus.line_option;
        assign output_sig_q[p] = port_bus.output_sig;
        assign line_intf_q[p] = port_bus.line_intf;
        assign build_out_q[p] = port_bus.build_out;

        e1cc_sync2 #(
            .WIDTH(2)
        ) u_rx_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .async_in({rx_line_tip[p], rx_line_ring[p]}),
            .sync_out(rx_pin_q)
        );

        // Interface enable taken from bit 5 of register 16h.
        assign sync_if_en = port_bus.line_option[e1cc_pkg::LOC_SYNC_IF_EN];
        // Transmit sync select is bit 0.
        assign tx_sync_sel = port_bus.line_intf[e1cc_pkg::LIC_TX_SYNC_SEL];
        assign tx_sync_now = sync_if_en ^ tx_sync_sel;
        assign rx_sync_now = sync_if_en;

        // Sync mode transmits the 2.048MHz source, not framed data.
        assign tx_src_tip = tx_sync_now ? tx_sync_tip[p] : tx_frame_tip[p];
        assign tx_src_ring = tx_sync_now ? tx_sync_ring[p] : tx_frame_ring[p];

        assign otm = e1cc_pkg::e1cc_otm_e'({port_bus.output_sig[e1cc_pkg::OSC_OTM_HI],
            port_bus.output_sig[e1cc_pkg::OSC_OTM_LO]});

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tx_line_tip_o[p] <= 1'b0;
                tx_line_ring_o[p] <= 1'b0;
                tx_line_tip_oe[p] <= 1'b0;
                tx_line_ring_oe[p] <= 1'b0;
            end else begin
                case (otm)
                    e1cc_pkg::OTM_NORMAL: begin
                        tx_line_tip_o[p] <= tx_src_tip;
                        tx_line_ring_o[p] <= tx_src_ring;
                        tx_line_tip_oe[p] <= 1'b1;
                        tx_line_ring_oe[p] <= 1'b1;
                    end
                    e1cc_pkg::OTM_HIZ: begin
                        tx_line_tip_o[p] <= 1'b0;
                        tx_line_ring_o[p] <= 1'b0;
                        tx_line_tip_oe[p] <= 1'b0;
                        tx_line_ring_oe[p] <= 1'b0;
                    end
                    e1cc_pkg::OTM_LOW: begin
                        tx_line_tip_o[p] <= 1'b0;
                        tx_line_ring_o[p] <= 1'b0;
                        tx_line_tip_oe[p] <= 1'b1;
                        tx_line_ring_oe[p] <= 1'b1;
                    end
                    default: begin
                        tx_line_tip_o[p] <= 1'b1;
                        tx_line_ring_o[p] <= 1'b1;
                        tx_line_tip_oe[p] <= 1'b1;
                        tx_line_ring_oe[p] <= 1'b1;
                    end
                endcase
            end
        end

        // Loopback takes the driven outputs and ignores the pins.
        assign rx_src_tip = port_bus.line_intf[e1cc_pkg::LIC_LOOPBACK] ?
            tx_line_tip_o[p] : rx_pin_q[1];
        assign rx_src_ring = port_bus.line_intf[e1cc_pkg::LIC_LOOPBACK] ?
            tx_line_ring_o[p] : rx_pin_q[0];

        // Receive sync mode steers the line away from the framer.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                rx_frame_tip[p] <= 1'b0;
                rx_frame_ring[p] <= 1'b0;
                rx_sync_tip[p] <= 1'b0;
                rx_sync_ring[p] <= 1'b0;
            end else begin
                rx_frame_tip[p] <= rx_sync_now ? 1'b0 : rx_src_tip;
                rx_frame_ring[p] <= rx_sync_now ? 1'b0 : rx_src_ring;
                rx_sync_tip[p] <= rx_sync_now ? rx_src_tip : 1'b0;
                rx_sync_ring[p] <= rx_sync_now ? rx_src_ring : 1'b0;
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                tx_sync_mode[p] <= 1'b0;
                rx_sync_mode[p] <= 1'b0;
            end else begin
                tx_sync_mode[p] <= tx_sync_now;
                rx_sync_mode[p] <= rx_sync_now;
            end
        end

        // Transformer ratio and build-out code out to the driver.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                transformer_ratio_select[p] <= 1'b0;
                build_out_code[p*e1cc_pkg::BUILD_OUT_W +: e1cc_pkg::BUILD_OUT_W] <= '0;
            end else begin
                transformer_ratio_select[p] <= port_bus.line_intf[e1cc_pkg::LIC_RATIO_SEL];
                build_out_code[p*e1cc_pkg::BUILD_OUT_W +: e1cc_pkg::BUILD_OUT_W] <=
                    port_bus.build_out[e1cc_pkg::BUILD_OUT_W-1:0];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sig_read_word[p*e1cc_pkg::SIG_W +: e1cc_pkg::SIG_W] <= '0;
            end else if (port_bus.output_sig[e1cc_pkg::OSC_SIG_READ_SEL]) begin
                sig_read_word[p*e1cc_pkg::SIG_W +: e1cc_pkg::SIG_W] <=
                    tx_sig_word[p*e1cc_pkg::SIG_W +: e1cc_pkg::SIG_W];
            end else begin
                sig_read_word[p*e1cc_pkg::SIG_W +: e1cc_pkg::SIG_W] <=
                    rx_sig_word[p*e1cc_pkg::SIG_W +: e1cc_pkg::SIG_W];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                timeslot16_signaling_insert[p] <= 1'b0;
            end else begin
                timeslot16_signaling_insert[p] <=
                    port_bus.output_sig[e1cc_pkg::OSC_TS16_INSERT];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                status_bit_ff[p] <= 1'b0;
            end else begin
                status_bit_ff[p] <= port_bus.output_sig[e1cc_pkg::OSC_STATUS_SEL] ?
                    sig_changed[p] : loss_tx_clock[p];
            end
        end

        assign status_two_bit2[p] = status_bit_ff[p];
    end
endmodule : e1cc_top

// [dv/e1cc_monitor.sv]
`timescale 1ns/1ps
module e1cc_monitor #(
    parameter int NUM_PORTS = 4
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Line drive.
    input wire logic [NUM_PORTS-1:0] tx_line_tip_o,
    input wire logic [NUM_PORTS-1:0] tx_line_tip_oe,
    input wire logic [NUM_PORTS-1:0] tx_line_ring_oe,
    // Status sources.
    input wire logic [NUM_PORTS-1:0] loss_tx_clock,
    input wire logic [NUM_PORTS-1:0] sig_changed,
    input wire logic [NUM_PORTS-1:0] status_two_bit2
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_oe_pair: assert property (tx_line_tip_oe == tx_line_ring_oe)
        else $error("line enables differ");
    a_hiz_low: assert property (!(|(tx_line_tip_o & ~tx_line_tip_oe)))
        else $error("undriven line output high");
    a_status_src: assert property ($past(aresetn) |-> (status_two_bit2
        & ~($past(loss_tx_clock) | $past(sig_changed))) == '0) else $error("status without source");
endmodule : e1cc_monitor

bind e1cc_top e1cc_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .tx_line_tip_o, .tx_line_tip_oe,
    .tx_line_ring_oe, .loss_tx_clock, .sig_changed, .status_two_bit2);

// [dv/e1cc_top_tb.sv]
`timescale 1ns/1ps
module e1cc_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr, build_out_code;
    logic [31:0] s_axi_wdata, s_axi_rdata, rx_sig_word, tx_sig_word, sig_read_word;
    logic [3:0] s_axi_wstrb, tx_frame_tip, tx_frame_ring, tx_sync_tip, tx_sync_ring;
    logic [3:0] tx_line_tip_o, tx_line_tip_oe, tx_line_ring_o, tx_line_ring_oe;
    logic [3:0] rx_line_tip, rx_line_ring, rx_frame_tip, rx_frame_ring, rx_sync_tip;
    logic [3:0] rx_sync_ring, tx_sync_mode, rx_sync_mode, transformer_ratio_select;
    logic [3:0] timeslot16_signaling_insert, loss_tx_clock, sig_changed, status_two_bit2;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] idx [4] = '{8'h16, 8'h1F, 8'h2F, 8'h30};
    int n_errors = 0;
    int cmp_count = 0;

    e1cc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_frame_tip,
        .tx_frame_ring, .tx_sync_tip, .tx_sync_ring, .tx_line_tip_o, .tx_line_tip_oe,
        .tx_line_ring_o, .tx_line_ring_oe, .rx_line_tip, .rx_line_ring, .rx_frame_tip,
        .rx_frame_ring, .rx_sync_tip, .rx_sync_ring, .tx_sync_mode, .rx_sync_mode,
        .transformer_ratio_select, .build_out_code, .rx_sig_word, .tx_sig_word,
        .sig_read_word, .timeslot16_signaling_insert, .loss_tx_clock, .sig_changed,
        .status_two_bit2);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic close_out;
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [1:0] p, input logic [7:0] i, input logic [7:0] d,
        input logic [1:0] er);
        s_axi_awaddr <= {p, i, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : wr

    task automatic rd(input logic [1:0] p, input logic [7:0] i, input logic [7:0] e,
        input logic [1:0] er);
        s_axi_araddr <= {p, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : rd

    task automatic bit_is(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : bit_is

    initial begin
        // Bready and rready stay high so every answer is taken when it appears.
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {tx_frame_ring, tx_sync_tip, tx_sync_ring, rx_line_ring, sig_changed} = 20'h0;
        {tx_frame_tip, rx_line_tip, loss_tx_clock} = 12'hFFF;
        rx_sig_word = 32'h44332211;
        tx_sig_word = 32'h88776655;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int p = 0; p < 4; p++) for (int k = 0; k < 4; k++) rd(p, idx[k], 8'h00, 2'b00);
        for (int m = 0; m < 4; m++) begin
            wr(1, 8'h16, {2'b00, m[1], 5'h00}, 2'b00);
            wr(1, 8'h1F, {7'h00, m[0]}, 2'b00);
            repeat (5) @(posedge aclk);
            bit_is("tx_sync_mode", m[1] ^ m[0], tx_sync_mode[1]);
            bit_is("rx_sync_mode", m[1], rx_sync_mode[1]);
            bit_is("tx_line_tip", !(m[1] ^ m[0]), tx_line_tip_o[1]);
            bit_is("rx_path", 1'b1, m[1] ? rx_sync_tip[1] : rx_frame_tip[1]);
        end
        for (int t = 0; t < 4; t++) begin
            wr(0, 8'h2F, {t[1:0], 6'h00}, 2'b00);
            repeat (2) @(posedge aclk);
            bit_is("line_oe", t != 1, tx_line_tip_oe[0]);
            bit_is("tip", t == 0 || t == 3, tx_line_tip_o[0]);
            bit_is("ring", t == 3, tx_line_ring_o[0]);
        end
        for (int k = 0; k < 2; k++) begin
            wr(0, 8'h2F, k ? 8'h38 : 8'h00, 2'b00);
            repeat (2) @(posedge aclk);
            chk("sig_read", k ? 8'h55 : 8'h11, sig_read_word[7:0]);
            bit_is("status_bit2", !k, status_two_bit2[0]);
            bit_is("ts16", k, timeslot16_signaling_insert[0]);
        end
        wr(0, 8'h1F, 8'h09, 2'b00);
        wr(0, 8'h30, 8'h03, 2'b00);
        wr(2, 8'h1F, 8'h08, 2'b00);
        repeat (2) @(posedge aclk);
        bit_is("ratio", 1'b1, transformer_ratio_select[0]);
        chk("build_out", 3'h3, build_out_code[2:0]);
        wr(0, 8'h2F, 8'h09, 2'b00);
        rd(0, 8'h1F, 8'h00, 2'b00);
        rd(0, 8'h30, 8'h00, 2'b00);
        rd(2, 8'h1F, 8'h08, 2'b00);
        wr(0, 8'h2F, 8'h09, 2'b00);
        rd(0, 8'h2F, 8'h08, 2'b00);
        rd(0, 8'h31, 8'h04, 2'b00);
        rx_line_tip <= 4'h7;
        rx_line_ring <= 4'hA;
        wr(3, 8'h1F, 8'h04, 2'b00);
        repeat (8) @(posedge aclk);
        bit_is("loop_tip", 1'b1, rx_frame_tip[3]);
        bit_is("loop_ring", 1'b0, rx_frame_ring[3]);
        bit_is("rx_sync_ring", 1'b1, rx_sync_ring[1]);
        // A write with byte lane 0 disabled must leave the register untouched.
        s_axi_wstrb <= 4'h0;
        wr(3, 8'h1F, 8'h00, 2'b00);
        rd(3, 8'h1F, 8'h04, 2'b00);
        wr(1, 8'h00, 8'h00, 2'b10);
        rd(1, 8'h00, 8'h00, 2'b10);
        wr(0, 8'h31, 8'h00, 2'b10);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end
endmodule : e1cc_top_tb
